// File: include/smc_pkg.sv
package smc_pkg;
  // register port: 4-bit index, 8-bit data
  localparam int unsigned AW = 4;
  localparam int unsigned DW = 8;
  localparam logic [3:0] OFS_STANDBY_CONTROL_REG  = 4'h0;
  localparam logic [3:0] OFS_ICR    = 4'h1;
  localparam logic [3:0] OFS_WCSR   = 4'h2;
  localparam logic [3:0] OFS_WCNT   = 4'h3;
  localparam logic [3:0] OFS_WRST   = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;
  // standby_control_reg fields
  localparam int unsigned SBY_BIT = 7;
  localparam int unsigned HIZ_BIT = 6;
  localparam logic [4:0] STANDBY_CONTROL_REG_LOW_ONES = 5'h1F;
  // interrupt_control_reg fields
  localparam int unsigned NMI_EDGE_SELECT_BIT = 0;
  // wdt_control_status_reg fields
  localparam int unsigned OVF_BIT  = 7;
  localparam int unsigned MODE_BIT = 6;
  localparam int unsigned TME_BIT  = 5;
  localparam int unsigned CKS_LSB  = 0;
  localparam logic [1:0] WCSR_GAP  = 2'h3;
  // reset values and last count
  localparam logic [7:0] WRST_RST  = 8'h00;
  localparam logic [7:0] WCNT_RST  = 8'h00;
  localparam logic [2:0] CKS_RST   = 3'h0;
  localparam logic [7:0] WCNT_LAST = 8'hFF;
  // prescaler: tick every 2^(cks+1) clocks
  localparam int unsigned PW = 12;
  localparam logic [11:0] PRE_ONE = 12'h001;
  localparam logic [11:0] PRE_TWO = 12'h002;
  typedef enum logic [1:0] {
    ST_RUN,
    ST_STANDBY,
    ST_WARMUP
  } smc_state_t;
endpackage

// File: src/smc_standby_ctl.sv
`timescale 1ns/10ps
// Notes on behaviour
// RULE1 - halt with standby select set leaves execution and enters standby
// RULE2 - standby stops system clock, cpu and all peripherals
// RULE3 - cpu registers and ram are kept through standby
// RULE4 - ports hold or float in standby per port float select
// RULE5 - entry initialises dma, timer pulse unit and serial registers
// RULE6 - entry leaves interrupt, bus, pin, port, pattern and standby registers alone
// RULE7 - entry clears watchdog bits 7-5 and reset status, keeps clock select and count
// RULE8 - only nmi, power-on reset or manual reset end standby
// RULE9 - nmi edge restarts oscillator, clock goes to watchdog only
// RULE10 - watchdog overflow restores chip clock and starts nmi exception
// RULE11 - software sets clock select so overflow covers oscillator settling
// RULE12 - falling edge wake: nmi high on entry, low on return
// RULE13 - rising edge wake: nmi low on entry, high on return; code ignores nmi_edge_select and wakes on a falling edge only
// RULE14 - reset pin falls with nmi high: power-on reset
// RULE15 - reset pin falls with nmi low: manual reset
// RULE16 - standby treats nmi as falling edge, rising edge never wakes
// RULE17 - nmi falling during standby wakes through nmi interrupt
// RULE18 - handler may set edge select and standby select then halt
// RULE19 - standby select cannot be set while watchdog runs
// RULE20 - port float select floats ports, cannot be set while watchdog runs
module smc_standby_ctl (
  input  wire logic                    i_clock,          // 25 MHz system clock
  input  wire logic                    i_sys_rst,        // async reset, active high
  input  wire logic                    i_clk_en,         // freezes all state when low
  input  wire logic                    i_halt_exec,      // halt instruction executed, pulse
  input  wire logic                    i_nmi_pin,        // nmi pin level
  input  wire logic                    i_chip_init_pin_n, // reset pin, active low
  input  wire logic [smc_pkg::AW-1:0]  i_addr,           // register index
  input  wire logic [smc_pkg::DW-1:0]  i_wr_data,        // write data
  input  wire logic                    i_wr,             // write strobe
  input  wire logic                    i_rd,             // read strobe
  output logic      [smc_pkg::DW-1:0]  o_rd_data,        // read data, cycle after strobe
  output logic                         o_clk_run,        // chip clock, cpu, peripherals run
  output logic                         o_wdt_clk_en,     // clock to watchdog
  output logic                         o_port_float,     // io ports to high impedance
  output logic                         o_periph_init,    // init pulse for dma, tpu, serial
  output logic                         o_nmi_exc,        // start nmi exception, pulse
  output logic                         o_por_req,        // power-on reset request, pulse
  output logic                         o_man_req,        // manual reset request, pulse
  output logic                         o_standby         // in standby or warmup
);

  typedef struct packed {
    smc_pkg::smc_state_t       st;
    logic                      standby_select_bit;
    logic                      port_float_select;
    logic                      nmi_edge_select;
    logic                      ovf;
    logic                      mode;
    logic                      wdt_run_enable;
    logic [2:0]                cks;
    logic [7:0]                wrst;
    logic [7:0]                wcnt;
    logic [smc_pkg::PW-1:0]    pre;
    logic                      nmi_prev;
    logic                      rst_prev;
    logic [smc_pkg::DW-1:0]    rd_data;
    logic                      clk_run;
    logic                      wdt_clk;
    logic                      port_float;
    logic                      periph_init;
    logic                      nmi_exc;
    logic                      por_req;
    logic                      man_req;
  } smc_regs_t;

  smc_regs_t s_q;
  smc_regs_t s_d;

  // prescaler tick once all low cks+1 bits are ones
  function automatic logic wdt_tick(input logic [smc_pkg::PW-1:0] pre,
                                    input logic [2:0]             cks);
    logic [smc_pkg::PW-1:0] m;
    m = (smc_pkg::PRE_TWO << cks) - smc_pkg::PRE_ONE;
    return (pre & m) == m;
  endfunction

  logic nmi_fall;
  logic rst_fall;
  logic tick;
  logic enter;
  logic in_sby;

  assign nmi_fall = s_q.nmi_prev & ~i_nmi_pin;
  assign rst_fall = s_q.rst_prev & ~i_chip_init_pin_n;
  assign tick     = wdt_tick(s_q.pre, s_q.cks);
  assign in_sby   = (s_q.st != smc_pkg::ST_RUN);
  assign enter    = (s_q.st == smc_pkg::ST_RUN) & i_halt_exec & s_q.standby_select_bit; // see RULE1

  always_comb begin
    s_d = s_q;
    s_d.nmi_prev    = i_nmi_pin;
    s_d.rst_prev    = i_chip_init_pin_n;
    s_d.periph_init = 1'b0;
    s_d.nmi_exc     = 1'b0;
    s_d.por_req     = 1'b0;
    s_d.man_req     = 1'b0;
    s_d.rd_data     = '0;

    if (i_wr && !in_sby) begin
      case (i_addr)
        smc_pkg::OFS_STANDBY_CONTROL_REG: begin
          // running watchdog blocks setting, clearing always allowed
          s_d.standby_select_bit = i_wr_data[smc_pkg::SBY_BIT] & (s_q.standby_select_bit | ~s_q.wdt_run_enable); // see RULE19
          s_d.port_float_select = i_wr_data[smc_pkg::HIZ_BIT] & (s_q.port_float_select | ~s_q.wdt_run_enable); // see RULE20
        end
        smc_pkg::OFS_ICR:  s_d.nmi_edge_select = i_wr_data[smc_pkg::NMI_EDGE_SELECT_BIT];
        smc_pkg::OFS_WCSR: begin
          s_d.ovf  = s_q.ovf & i_wr_data[smc_pkg::OVF_BIT];
          s_d.mode = i_wr_data[smc_pkg::MODE_BIT];
          s_d.wdt_run_enable  = i_wr_data[smc_pkg::TME_BIT];
          s_d.cks  = i_wr_data[smc_pkg::CKS_LSB +: 3];
        end
        smc_pkg::OFS_WCNT: s_d.wcnt = i_wr_data;
        smc_pkg::OFS_WRST: s_d.wrst = i_wr_data;
        default: ;
      endcase
    end

    if (i_rd) begin
      case (i_addr)
        smc_pkg::OFS_STANDBY_CONTROL_REG:  s_d.rd_data = {s_q.standby_select_bit, s_q.port_float_select, 1'b0, smc_pkg::STANDBY_CONTROL_REG_LOW_ONES};
        smc_pkg::OFS_ICR:    s_d.rd_data = {7'h00, s_q.nmi_edge_select};
        smc_pkg::OFS_WCSR:   s_d.rd_data = {s_q.ovf, s_q.mode, s_q.wdt_run_enable, smc_pkg::WCSR_GAP,
                                            s_q.cks};
        smc_pkg::OFS_WCNT:   s_d.rd_data = s_q.wcnt;
        smc_pkg::OFS_WRST:   s_d.rd_data = s_q.wrst;
        smc_pkg::OFS_STATUS: s_d.rd_data = {5'h00, s_q.port_float,
                                            s_q.st == smc_pkg::ST_WARMUP,
                                            s_q.st == smc_pkg::ST_STANDBY};
        default:             s_d.rd_data = '0;
      endcase
    end

    case (s_q.st)
      smc_pkg::ST_RUN: begin
        // free-running watchdog in normal operation; overflow set beats clear
        if (s_q.wdt_run_enable) begin
          s_d.pre = s_q.pre + smc_pkg::PRE_ONE;
          if (tick) begin
            s_d.wcnt = s_q.wcnt + 8'h01;
            if (s_q.wcnt == smc_pkg::WCNT_LAST) s_d.ovf = 1'b1;
          end
        end
        if (enter) begin
          s_d.st          = smc_pkg::ST_STANDBY;
          s_d.clk_run     = 1'b0;          // see RULE2
          s_d.wdt_clk     = 1'b0;          // see RULE2
          s_d.port_float  = s_q.port_float_select;       // see RULE4
          s_d.periph_init = 1'b1;          // see RULE5
          // count and clock select kept; sby, hiz, nmi_edge_select untouched, see RULE6
          s_d.wcnt = s_q.wcnt;             // see RULE7
          s_d.ovf  = 1'b0;                 // see RULE7
          s_d.mode = 1'b0;                 // see RULE7
          s_d.wdt_run_enable  = 1'b0;                 // see RULE7
          s_d.wrst = smc_pkg::WRST_RST;    // see RULE7
          s_d.pre  = '0;
        end
      end
      smc_pkg::ST_STANDBY: begin
        // nmi_edge_select ignored here: only a falling edge wakes
        if (rst_fall) begin                // see RULE8
          s_d.st         = smc_pkg::ST_RUN;
          s_d.clk_run    = 1'b1;
          s_d.wdt_clk    = 1'b1;
          s_d.port_float = 1'b0;
          s_d.por_req    = i_nmi_pin;      // see RULE14
          s_d.man_req    = ~i_nmi_pin;     // see RULE15
        end else if (nmi_fall) begin       // see RULE16 RULE17
          s_d.st      = smc_pkg::ST_WARMUP;
          s_d.wdt_clk = 1'b1;              // see RULE9
        end
      end
      smc_pkg::ST_WARMUP: begin
        s_d.pre = s_q.pre + smc_pkg::PRE_ONE;
        if (rst_fall) begin                // see RULE8
          s_d.st         = smc_pkg::ST_RUN;
          s_d.clk_run    = 1'b1;
          s_d.port_float = 1'b0;
          s_d.por_req    = i_nmi_pin;      // see RULE14
          s_d.man_req    = ~i_nmi_pin;     // see RULE15
        end else if (tick) begin
          s_d.wcnt = s_q.wcnt + 8'h01;
          // settling length is software's duty via cks
          if (s_q.wcnt == smc_pkg::WCNT_LAST) begin // see RULE10 RULE11
            s_d.st         = smc_pkg::ST_RUN;
            s_d.clk_run    = 1'b1;
            s_d.port_float = 1'b0;
            s_d.nmi_exc    = 1'b1;
          end
        end
      end
      default: s_d.st = smc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q          <= '0;
      s_q.st       <= smc_pkg::ST_RUN;
      s_q.cks      <= smc_pkg::CKS_RST;
      s_q.wrst     <= smc_pkg::WRST_RST;
      s_q.wcnt     <= smc_pkg::WCNT_RST;
      s_q.nmi_prev <= 1'b1;
      s_q.rst_prev <= 1'b1;
      s_q.clk_run  <= 1'b1;
      s_q.wdt_clk  <= 1'b1;
    end else if (i_clk_en) begin
      // cpu state and ram untouched: clock gating only, no reset
      s_q <= s_d;                          // see RULE3
    end
  end

  assign o_rd_data     = s_q.rd_data;
  assign o_clk_run     = s_q.clk_run;
  assign o_wdt_clk_en  = s_q.wdt_clk;
  assign o_port_float  = s_q.port_float;
  assign o_periph_init = s_q.periph_init;
  assign o_nmi_exc     = s_q.nmi_exc;
  assign o_por_req     = s_q.por_req;
  assign o_man_req     = s_q.man_req;
  assign o_standby     = s_q.st != smc_pkg::ST_RUN;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  AST_ENTER: assert property (i_clk_en && enter |=> s_q.st == smc_pkg::ST_STANDBY && // see RULE1
                              o_periph_init && !o_clk_run)
    else $error("halt with standby select did not enter standby");
  AST_CLK_STOP: assert property (o_clk_run == (s_q.st == smc_pkg::ST_RUN)) // see RULE2
    else $error("chip clock running in standby");
  AST_FLOAT: assert property (i_clk_en && enter |=> o_port_float == $past(s_q.port_float_select)) // see RULE4
    else $error("port float does not follow select");
  AST_WDT_INIT: assert property (i_clk_en && enter |=> !s_q.wdt_run_enable && !s_q.ovf && // see RULE7
                                 s_q.wrst == smc_pkg::WRST_RST && $stable(s_q.wcnt) &&
                                 $stable(s_q.cks) && $stable(s_q.standby_select_bit) && $stable(s_q.nmi_edge_select))
    else $error("watchdog or retained registers wrong on entry");
  AST_NO_RISE: assert property (i_clk_en && s_q.st == smc_pkg::ST_STANDBY && !rst_fall && // see RULE16
                                !nmi_fall |=> s_q.st == smc_pkg::ST_STANDBY)
    else $error("standby left without nmi fall or reset");
  AST_WAKE: assert property (i_clk_en && s_q.st == smc_pkg::ST_STANDBY && nmi_fall && // see RULE9
                             !rst_fall |=> s_q.st == smc_pkg::ST_WARMUP && o_wdt_clk_en &&
                             !o_clk_run)
    else $error("nmi fall did not start warmup");
  AST_EXIT: assert property (i_clk_en && s_q.st == smc_pkg::ST_WARMUP && !rst_fall && tick && // see RULE10
                             s_q.wcnt == smc_pkg::WCNT_LAST |=> o_nmi_exc && o_clk_run
                             ##1 !o_nmi_exc)
    else $error("overflow did not end warmup with nmi exception");
  AST_POR: assert property (i_clk_en && in_sby && rst_fall |=> // see RULE14
                            (o_por_req == $past(i_nmi_pin)) && (o_man_req == !$past(i_nmi_pin))
                            && o_clk_run)
    else $error("reset pin did not give the right reset");
  AST_LOCK: assert property (i_clk_en && i_wr && !in_sby && i_addr == smc_pkg::OFS_STANDBY_CONTROL_REG && // see RULE19
                             s_q.wdt_run_enable && !s_q.standby_select_bit && !s_q.port_float_select |=> !s_q.standby_select_bit && !s_q.port_float_select)
    else $error("standby select set while watchdog runs");

  COV_NMI_WAKE: cover property (s_q.st == smc_pkg::ST_WARMUP ##[1:1000] o_nmi_exc);
  COV_POR: cover property (in_sby ##1 o_por_req);
  COV_MAN: cover property (in_sby ##1 o_man_req);

endmodule // smc_standby_ctl

// File: dv/smc_pin_drv.sv
`timescale 1ns/10ps
module smc_pin_drv (
  input  wire logic i_clock,           // system clock
  input  wire logic i_nmi_level,       // level asked of the nmi pin
  input  wire logic i_rst_go,          // start a reset pin pulse
  output logic      o_nmi_pin,         // nmi pin
  output logic      o_chip_init_pin_n  // reset pin, pulled up when released
);
  int unsigned low_cnt;
  initial begin
    o_nmi_pin = 1'b1;
    o_chip_init_pin_n = 1'b1;
    low_cnt = 0;
  end
  always @(posedge i_clock) begin
    // level copied from i_nmi_level one clock later
    o_nmi_pin <= i_nmi_level;
    if (i_rst_go) begin
      low_cnt <= 3;
    end else if (low_cnt != 0) begin
      low_cnt <= low_cnt - 1;
    end
    // released pin returns to its pull-up level
    o_chip_init_pin_n <= !(i_rst_go || low_cnt > 1);
  end
endmodule // smc_pin_drv

// File: dv/standby_mode_control_tb.sv
`timescale 1ns/10ps
module standby_mode_control_tb;
  logic clock, sys_rst, halt, wr, rd, nmi_lvl, rst_go, nmi, rst_n;
  logic [3:0] addr;
  logic [7:0] wdat, rdat;
  logic run, wclk, flt, init, nexc, por, man, standby_select_bit;
  int err_count, comparisons, n, cks;
  int mdl [7];
  smc_pin_drv drv (.i_clock(clock), .i_nmi_level(nmi_lvl), .i_rst_go(rst_go),
                   .o_nmi_pin(nmi), .o_chip_init_pin_n(rst_n));
  smc_standby_ctl uut (.i_clock(clock), .i_sys_rst(sys_rst), .i_clk_en(1'b1),
    .i_halt_exec(halt), .i_nmi_pin(nmi), .i_chip_init_pin_n(rst_n), .i_addr(addr),
    .i_wr_data(wdat), .i_wr(wr), .i_rd(rd), .o_rd_data(rdat), .o_clk_run(run),
    .o_wdt_clk_en(wclk), .o_port_float(flt), .o_periph_init(init), .o_nmi_exc(nexc),
    .o_por_req(por), .o_man_req(man), .o_standby(standby_select_bit));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // model of the register file: sby/hiz refused while the watchdog runs
  task automatic wr_reg(input int a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= 4'(a);
    wdat <= d;
    @(posedge clock);
    wr <= 1'b0;
    if (a == 0) mdl[0] = ((mdl[2] & 8'h20) != 0) ? mdl[0] : ((d & 8'hC0) | 8'h1F);
    else if (a == 2) mdl[2] = (d & 8'h67) | 8'h18;
    else if (a == 1) mdl[1] = d & 8'h01;
    else if (a < 6) mdl[a] = d;
  endtask
  task automatic rd_chk(input int a);
    @(posedge clock);
    rd <= 1'b1;
    addr <= 4'(a);
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdat, 8'(mdl[a]));
  endtask
  task automatic do_halt();
    @(posedge clock);
    halt <= 1'b1;
    @(posedge clock);
    halt <= 1'b0;
    #1;
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: return wclk;
      1: return nexc;
      2: return por;
      default: return man;
    endcase
  endfunction
  task automatic wait_hi(input int w, input int lim, output int cnt);
    cnt = 0;
    while (sel(w) !== 1'b1 && cnt < lim) begin
      @(posedge clock);
      #1 cnt++;
    end
    chk({7'h0, sel(w)}, 8'h01);
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    results();
  end
  initial begin
    {sys_rst, halt, wr, rd, rst_go, addr, wdat} = {1'b1, 4'h0, 4'h0, 8'h00};
    nmi_lvl = 1'b1;
    mdl = '{8'h1F, 0, 8'h18, 0, 0, 0, 0};
    void'($urandom(32'ha52253bf));
    cks = $urandom % 8;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    for (int a = 0; a < 7; a++) rd_chk(a);
    wr_reg(2, 8'h20);
    wr_reg(0, 8'hC0);
    rd_chk(0);
    wr_reg(2, 8'(cks));
    wr_reg(0, 8'hC0);
    rd_chk(0);
    wr_reg(3, 8'hFC);
    wr_reg(4, 8'($urandom));
    do_halt();
    chk({3'h0, run, wclk, init, flt, standby_select_bit}, 8'h07);
    mdl[2] = mdl[2] & 8'h1F;
    mdl[4] = 0;
    for (int a = 0; a < 5; a++) rd_chk(a);
    do_halt();
    repeat (5) @(posedge clock);
    chk({6'h0, wclk, standby_select_bit}, 8'h01);
    nmi_lvl <= 1'b0;
    wait_hi(0, 4, n);
    chk({7'h0, run}, 8'h00);
    wait_hi(1, 3000, n);
    chk({7'h0, n >= (3 << (cks + 1)) && n <= (4 << (cks + 1)) + 4}, 8'h01);
    chk({6'h0, run, standby_select_bit}, 8'h02);
    mdl[3] = 0;
    rd_chk(3);
    wr_reg(1, 8'h01);
    do_halt();
    nmi_lvl <= 1'b1;
    repeat (8) @(posedge clock);
    #1 chk({6'h0, wclk, standby_select_bit}, 8'h01);
    rst_go <= 1'b1;
    @(posedge clock);
    rst_go <= 1'b0;
    wait_hi(2, 8, n);
    chk({6'h0, man, standby_select_bit}, 8'h00);
    nmi_lvl <= 1'b0;
    repeat (4) @(posedge clock);
    wr_reg(2, 8'h00);
    wr_reg(0, 8'h80);
    do_halt();
    chk({6'h0, flt, standby_select_bit}, 8'h01);
    rst_go <= 1'b1;
    @(posedge clock);
    rst_go <= 1'b0;
    wait_hi(3, 8, n);
    chk({6'h0, por, standby_select_bit}, 8'h00);
    results();
  end
endmodule // standby_mode_control_tb
